// ### ppmp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ppmp_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // MAC to PHY
  input wire logic [7:0] tx_byte_in,
  input wire logic detect_or_loopback_req,
  input wire logic tx_electrical_idle_force,
  input wire logic phy_reset_n,
  input wire logic power_state_code_bit0,
  input wire logic power_state_code_bit1,
  input wire logic mac_source_clock,
  // PHY to MAC
  input wire logic phy_source_clock,
  input wire logic rx_lock_valid,
  input wire logic phy_done_strobe
);
  import ppmp_pkg::*;
  logic [1:0] code;
  logic [5:0] quiet_ff;
  logic [5:0] nxt_quiet;
  assign code = {power_state_code_bit1, power_state_code_bit0};
  // Time spent held in reset or in P1/P2; saturates so it never wraps
  always_comb begin
    nxt_quiet = 6'h0;
    if (!phy_reset_n || power_state_code_bit1) begin
      nxt_quiet = (quiet_ff == 6'h3f) ? quiet_ff : quiet_ff + 6'h1;
    end
  end
  always_ff @(posedge clk) begin
    quiet_ff <= rst ? 6'h0 : nxt_quiet;
  end
  AST_RST_STATE:
  assert property (@(posedge clk) rst |=> code == PWR_RESET && !phy_reset_n
    && !detect_or_loopback_req && tx_electrical_idle_force) else $error("reset state wrong");
  AST_HELD_IN_RESET:
  assert property (@(posedge clk) disable iff (rst) !phy_reset_n |->
    code == PWR_RESET && !detect_or_loopback_req) else $error("code or detect in reset");
  AST_IDLE_LOWPWR:
  assert property (@(posedge clk) disable iff (rst) (code == PWR_P0S || code == PWR_P1)
    && $stable(code) |-> tx_electrical_idle_force) else $error("idle not forced");
  AST_TX_ON_FALL:
  assert property (@(posedge clk) disable iff (rst) $changed(tx_byte_in) |->
    $fell(mac_source_clock)) else $error("tx byte moved off the falling edge");
  AST_MAC_PERIOD:
  assert property (@(posedge clk) disable iff (rst) $rose(mac_source_clock) |=>
    mac_source_clock [*3] ##1 !mac_source_clock [*4] ##1 mac_source_clock)
    else $error("mac clock period wrong");
  AST_PHY_PERIOD:
  assert property (@(posedge clk) disable iff (rst) $rose(phy_source_clock) |=>
    phy_source_clock [*3] ##1 !phy_source_clock [*4] ##1 phy_source_clock)
    else $error("phy clock period wrong");
  AST_DONE_ONE_PERIOD:
  assert property (@(posedge clk) disable iff (rst) $rose(phy_done_strobe) |->
    phy_done_strobe [*8] ##1 !phy_done_strobe) else $error("done strobe width wrong");
  AST_QUIET_NO_VALID:
  assert property (@(posedge clk) disable iff (rst) quiet_ff >= 6'h28 |-> !rx_lock_valid)
    else $error("valid while in reset or low power");
endmodule
`default_nettype wire

// ### ppmp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ppmp_if;
  logic [7:0] tx_byte_in;
  logic tx_symbol_is_control;
  logic detect_or_loopback_req;
  logic tx_electrical_idle_force;
  logic compliance_neg_disparity;
  logic rx_polarity_invert;
  logic phy_reset_n;
  logic power_state_code_bit0;
  logic power_state_code_bit1;
  logic mac_source_clock;
  logic [7:0] rx_byte_out;
  logic rx_symbol_is_control;
  logic rx_lock_valid;
  logic phy_done_strobe;
  logic phy_source_clock;

  modport phy (
    input tx_byte_in, tx_symbol_is_control, detect_or_loopback_req,
    input tx_electrical_idle_force, compliance_neg_disparity, rx_polarity_invert,
    input phy_reset_n, power_state_code_bit0, power_state_code_bit1, mac_source_clock,
    output rx_byte_out, rx_symbol_is_control, rx_lock_valid, phy_done_strobe,
    output phy_source_clock
  );
  modport mac (
    output tx_byte_in, tx_symbol_is_control, detect_or_loopback_req,
    output tx_electrical_idle_force, compliance_neg_disparity, rx_polarity_invert,
    output phy_reset_n, power_state_code_bit0, power_state_code_bit1, mac_source_clock,
    input rx_byte_out, rx_symbol_is_control, rx_lock_valid, phy_done_strobe,
    input phy_source_clock
  );
endinterface
`default_nettype wire

// ### ppmp_mac.sv
`timescale 1ns/1ns
`default_nettype none
module ppmp_mac (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ppmp_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transmit stream
  input wire logic [ppmp_pkg::BYTE_W-1:0] tx_byte,
  input wire logic tx_k,
  output logic tx_take,
  // Receive stream
  output logic [ppmp_pkg::BYTE_W-1:0] rx_byte,
  output logic rx_k,
  output logic rx_valid,
  output logic rx_strobe,
  // Parallel port
  ppmp_if.mac lnk
);
  import ppmp_pkg::*;

  typedef struct packed {
    logic [2:0] div;
    logic mclk;
    logic [BYTE_W-1:0] o_byte;
    logic o_k, o_det, o_idle, o_comp, o_pol, o_rstn;
    logic [PWR_W-1:0] o_pwr;
    logic p_s1, p_s2, p_prev;
    logic [RSP_W-1:0] r_s1, r_s2;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_k, rx_valid, rx_strobe;
    logic [RSP_W-1:0] rx_last;
    logic done_sticky;
    logic [CTRL_W-1:0] ctrl;
    logic ack;
    logic [31:0] rdata;
  } ppmp_mac_state_t;

  ppmp_mac_state_t s_ff, nxt_s;
  logic mfall;
  logic prise;
  logic req;
  logic [PWR_W-1:0] ctl_pwr;
  logic eff_idle;

  function automatic logic [31:0] reg_read(input logic [3:0] a, input ppmp_mac_state_t s);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      OFS_CTRL: d[CTRL_W-1:0] = s.ctrl;
      OFS_STATUS: d[ST_RUN:ST_DONE] = {s.o_rstn, s.o_idle, s.rx_valid, s.done_sticky};
      OFS_RX_LAST: d[RSP_W-1:0] = s.rx_last;
      default: d = 32'h0;
    endcase
    return d;
  endfunction

  assign ctl_pwr = s_ff.ctrl[CTL_PWR +: PWR_W];
  // Idle is kept asserted while the CTRL power field selects P0s or P1, even if software forgets
  assign eff_idle = s_ff.ctrl[CTL_IDLE] | (ctl_pwr == PWR_P0S) | (ctl_pwr == PWR_P1);
  assign mfall = (s_ff.div == LINK_HALF_LAST) & s_ff.mclk;
  assign prise = s_ff.p_s2 & ~s_ff.p_prev;
  assign req = avs_read | avs_write;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.div = s_ff.div + 3'h1;
    if (s_ff.div == LINK_HALF_LAST) begin
      nxt_s.div = 3'h0;
      nxt_s.mclk = ~s_ff.mclk;
    end
    // Outputs change on the falling edge so they are settled at the rising one
    if (mfall) begin
      nxt_s.o_byte = tx_byte;
      nxt_s.o_k = tx_k;
      nxt_s.o_det = s_ff.ctrl[CTL_DETECT] & s_ff.ctrl[CTL_RUN];
      nxt_s.o_idle = eff_idle;
      nxt_s.o_comp = s_ff.ctrl[CTL_COMPL];
      nxt_s.o_pol = s_ff.ctrl[CTL_POL];
      nxt_s.o_rstn = s_ff.ctrl[CTL_RUN];
      nxt_s.o_pwr = s_ff.ctrl[CTL_RUN] ? ctl_pwr : PWR_RESET;
    end
    nxt_s.p_s1 = lnk.phy_source_clock;
    nxt_s.p_s2 = s_ff.p_s1;
    nxt_s.p_prev = s_ff.p_s2;
    nxt_s.r_s1 = {lnk.phy_done_strobe, lnk.rx_lock_valid, lnk.rx_symbol_is_control,
                  lnk.rx_byte_out};
    nxt_s.r_s2 = s_ff.r_s1;
    nxt_s.rx_strobe = 1'b0;
    nxt_s.ack = req & ~s_ff.ack;
    if (req & ~s_ff.ack & avs_read) begin
      nxt_s.rdata = reg_read(avs_address, s_ff);
    end
    if (avs_write & s_ff.ack) begin
      if (avs_address == OFS_CTRL) begin
        nxt_s.ctrl = avs_writedata[CTRL_W-1:0];
      end else if (avs_address == OFS_STATUS && avs_writedata[ST_DONE]) begin
        nxt_s.done_sticky = 1'b0;
      end
    end
    // Sampled on the PHY clock rising edge; a done arriving with a clear wins
    if (prise) begin
      nxt_s.rx_byte = s_ff.r_s2[BYTE_W-1:0];
      nxt_s.rx_k = s_ff.r_s2[R_K];
      nxt_s.rx_valid = s_ff.r_s2[R_VALID];
      nxt_s.rx_strobe = 1'b1;
      if (s_ff.r_s2[R_VALID]) begin
        nxt_s.rx_last = s_ff.r_s2;
      end
      if (s_ff.r_s2[R_DONE]) begin
        nxt_s.done_sticky = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.ctrl <= CTRL_RESET;
      s_ff.o_pwr <= PWR_RESET;
      s_ff.o_idle <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata = s_ff.rdata;
  assign avs_waitrequest = req & ~s_ff.ack;
  assign tx_take = mfall;
  assign rx_byte = s_ff.rx_byte;
  assign rx_k = s_ff.rx_k;
  assign rx_valid = s_ff.rx_valid;
  assign rx_strobe = s_ff.rx_strobe;
  assign lnk.mac_source_clock = s_ff.mclk;
  assign lnk.tx_byte_in = s_ff.o_byte;
  assign lnk.tx_symbol_is_control = s_ff.o_k;
  assign lnk.detect_or_loopback_req = s_ff.o_det;
  assign lnk.tx_electrical_idle_force = s_ff.o_idle;
  assign lnk.compliance_neg_disparity = s_ff.o_comp;
  assign lnk.rx_polarity_invert = s_ff.o_pol;
  assign lnk.phy_reset_n = s_ff.o_rstn;
  assign lnk.power_state_code_bit0 = s_ff.o_pwr[0];
  assign lnk.power_state_code_bit1 = s_ff.o_pwr[1];
endmodule
`default_nettype wire

// ### ppmp_phy.sv
`timescale 1ns/1ns
`default_nettype none
module ppmp_phy (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parallel port
  ppmp_if.phy lnk,
  // Toward the serializer
  output logic [ppmp_pkg::BYTE_W-1:0] line_tx_byte,
  output logic line_tx_k,
  output logic line_tx_idle,
  output logic line_tx_neg_disp,
  output logic line_tx_strobe,
  // From the deserializer and detector
  input wire logic [ppmp_pkg::BYTE_W-1:0] line_rx_byte,
  input wire logic line_rx_k,
  input wire logic line_rx_present,
  input wire logic line_rx_lock,
  input wire logic line_far_receiver,
  // Status
  output logic phy_in_reset,
  output logic [ppmp_pkg::PWR_W-1:0] phy_power_state,
  output logic detect_found,
  output logic loopback_active
);
  import ppmp_pkg::*;

  typedef enum logic [1:0] {
    PH_RESET,
    PH_RUN,
    PH_DETECT
  } ppmp_phase_t;

  typedef struct packed {
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_prev;
    logic [CMD_W-1:0] in_s1;
    logic [CMD_W-1:0] in_s2;
    logic [CMD_W-1:0] cmd;
    logic det_prev;
    logic [2:0] div;
    logic pclk;
    ppmp_phase_t phase;
    logic [PWR_W-1:0] pwr;
    logic [3:0] det_cnt;
    logic found;
    logic [1:0] lock_cnt;
    logic done_pend;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_k;
    logic rx_valid;
    logic done;
    logic [BYTE_W-1:0] tx_byte;
    logic tx_k;
    logic tx_idle;
    logic tx_neg;
    logic tx_strobe;
  } ppmp_phy_state_t;

  ppmp_phy_state_t s_ff, nxt_s;
  logic mrise;
  logic pfall;
  logic [CMD_W-1:0] pins;
  logic loop;
  logic det_rise;
  logic rx_on;

  function automatic logic [PWR_W-1:0] cmd_pwr(input logic [CMD_W-1:0] c);
    return c[F_PWR +: PWR_W];
  endfunction

  function automatic logic [BYTE_W-1:0] cmd_byte(input logic [CMD_W-1:0] c);
    return c[BYTE_W-1:0];
  endfunction

  // All MAC inputs travel as one word so they stay aligned with the clock copy
  assign pins = {lnk.power_state_code_bit1, lnk.power_state_code_bit0, lnk.phy_reset_n,
                 lnk.rx_polarity_invert, lnk.compliance_neg_disparity,
                 lnk.tx_electrical_idle_force, lnk.detect_or_loopback_req,
                 lnk.tx_symbol_is_control, lnk.tx_byte_in};

  assign mrise = s_ff.mclk_s2 & ~s_ff.mclk_prev;
  assign pfall = (s_ff.div == LINK_HALF_LAST) & s_ff.pclk;
  assign det_rise = s_ff.in_s2[F_DET] & ~s_ff.det_prev;
  // Loopback only from P0; a request in P1 means receiver detection
  assign loop = (s_ff.phase == PH_RUN) & (s_ff.pwr == PWR_P0) & s_ff.cmd[F_DET];
  // Receiver runs in P0 and P0s only; P1 and P2 keep it quiet
  assign rx_on = (s_ff.pwr == PWR_P0) | (s_ff.pwr == PWR_P0S);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.mclk_s1 = lnk.mac_source_clock;
    nxt_s.mclk_s2 = s_ff.mclk_s1;
    nxt_s.mclk_prev = s_ff.mclk_s2;
    nxt_s.in_s1 = pins;
    nxt_s.in_s2 = s_ff.in_s1;
    nxt_s.tx_strobe = 1'b0;

    // Own receive clock; the receive outputs and done strobe to the MAC change at its falling edge
    nxt_s.div = s_ff.div + 3'h1;
    if (s_ff.div == LINK_HALF_LAST) begin
      nxt_s.div = 3'h0;
      nxt_s.pclk = ~s_ff.pclk;
    end

    if (pfall) begin
      nxt_s.done = s_ff.done_pend;
      nxt_s.done_pend = 1'b0;
      if (line_rx_lock & line_rx_present & rx_on) begin
        if (s_ff.lock_cnt != LOCK_LINK_CYC) begin
          nxt_s.lock_cnt = s_ff.lock_cnt + 2'h1;
        end
      end else begin
        nxt_s.lock_cnt = 2'h0;
      end
      if (s_ff.phase == PH_RESET) begin
        nxt_s.rx_byte = '0;
        nxt_s.rx_k = 1'b0;
        nxt_s.rx_valid = 1'b0;
        nxt_s.lock_cnt = 2'h0;
      end else if (loop) begin
        nxt_s.rx_byte = cmd_byte(s_ff.cmd);
        nxt_s.rx_k = s_ff.cmd[F_K];
        nxt_s.rx_valid = 1'b1;
      end else begin
        nxt_s.rx_byte = line_rx_byte ^ {BYTE_W{s_ff.cmd[F_POL]}};
        nxt_s.rx_k = line_rx_k;
        nxt_s.rx_valid = (s_ff.lock_cnt == LOCK_LINK_CYC) & line_rx_lock
                         & line_rx_present & rx_on;
      end
    end

    // Placed after the clear above so a new completion is never lost
    if (mrise) begin
      nxt_s.cmd = s_ff.in_s2;
      nxt_s.det_prev = s_ff.in_s2[F_DET];
      unique case (s_ff.phase)
        PH_RESET: begin
          if (s_ff.in_s2[F_RSTN]) begin
            nxt_s.phase = PH_RUN;
            nxt_s.pwr = cmd_pwr(s_ff.in_s2);
            nxt_s.done_pend = 1'b1;
          end
        end
        PH_RUN: begin
          if (cmd_pwr(s_ff.in_s2) != s_ff.pwr) begin
            nxt_s.pwr = cmd_pwr(s_ff.in_s2);
            nxt_s.done_pend = 1'b1;
          end else if (det_rise && s_ff.pwr == PWR_P1) begin
            nxt_s.phase = PH_DETECT;
            nxt_s.det_cnt = DETECT_LINK_CYC;
          end
        end
        PH_DETECT: begin
          if (s_ff.det_cnt == 4'h0) begin
            nxt_s.found = line_far_receiver;
            nxt_s.done_pend = 1'b1;
            nxt_s.phase = PH_RUN;
          end else begin
            nxt_s.det_cnt = s_ff.det_cnt - 4'h1;
          end
        end
      endcase
      if (!s_ff.in_s2[F_RSTN]) begin
        nxt_s.phase = PH_RESET;
        nxt_s.pwr = PWR_RESET;
        nxt_s.found = 1'b0;
        nxt_s.done_pend = 1'b0;
      end
      nxt_s.tx_byte = cmd_byte(s_ff.in_s2);
      nxt_s.tx_k = s_ff.in_s2[F_K];
      nxt_s.tx_neg = s_ff.in_s2[F_COMP];
      // A missing idle in P0s or P1 is not repaired here
      nxt_s.tx_idle = s_ff.in_s2[F_IDLE] | ~s_ff.in_s2[F_RSTN];
      nxt_s.tx_strobe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.pwr <= PWR_RESET;
      s_ff.tx_idle <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.phy_source_clock = s_ff.pclk;
  assign lnk.rx_byte_out = s_ff.rx_byte;
  assign lnk.rx_symbol_is_control = s_ff.rx_k;
  assign lnk.rx_lock_valid = s_ff.rx_valid;
  assign lnk.phy_done_strobe = s_ff.done;
  assign line_tx_byte = s_ff.tx_byte;
  assign line_tx_k = s_ff.tx_k;
  assign line_tx_idle = s_ff.tx_idle;
  assign line_tx_neg_disp = s_ff.tx_neg;
  assign line_tx_strobe = s_ff.tx_strobe;
  assign phy_in_reset = (s_ff.phase == PH_RESET);
  assign phy_power_state = s_ff.pwr;
  assign detect_found = s_ff.found;
  assign loopback_active = loop;
endmodule
`default_nettype wire

// ### ppmp_pkg.sv
`default_nettype none
package ppmp_pkg;
  // Widths of the parallel port
  localparam int BYTE_W = 8;
  localparam int PWR_W = 2;

  // Power-state codes on the two power-down inputs
  localparam logic [1:0] PWR_P0 = 2'h0;
  localparam logic [1:0] PWR_P0S = 2'h1;
  localparam logic [1:0] PWR_P1 = 2'h2;
  localparam logic [1:0] PWR_P2 = 2'h3;
  localparam logic [1:0] PWR_RESET = PWR_P1;

  // Link clock made by each end from clk by a divider
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 40;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LINK_HALF_LAST = 3'(LINK_HALF_CYC - 1);

  // Receiver detection and lock, counted in link clock periods
  localparam logic [3:0] DETECT_LINK_CYC = 4'ha;
  localparam logic [1:0] LOCK_LINK_CYC = 2'h3;

  // Packing of the MAC-to-PHY inputs inside the PHY
  localparam int CMD_W = 16;
  localparam int F_K = 8;
  localparam int F_DET = 9;
  localparam int F_IDLE = 10;
  localparam int F_COMP = 11;
  localparam int F_POL = 12;
  localparam int F_RSTN = 13;
  localparam int F_PWR = 14;

  // Packing of the PHY-to-MAC outputs inside the MAC
  localparam int RSP_W = 11;
  localparam int R_K = 8;
  localparam int R_VALID = 9;
  localparam int R_DONE = 10;

  // Controller registers on Avalon-MM
  localparam int AVS_ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RX_LAST = 4'h8;
  localparam int CTRL_W = 7;
  localparam int CTL_DETECT = 0;
  localparam int CTL_IDLE = 1;
  localparam int CTL_COMPL = 2;
  localparam int CTL_POL = 3;
  localparam int CTL_RUN = 4;
  localparam int CTL_PWR = 5;
  localparam logic [6:0] CTRL_RESET = 7'h40;
  localparam int ST_DONE = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_IDLE = 2;
  localparam int ST_RUN = 3;
endpackage
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(exp, got, what) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb_top;
  import ppmp_pkg::*;
  localparam int SETTLE = 16 * LINK_HALF_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] tx_byte = 8'h0;
  logic tx_k = 1'b0;
  logic [7:0] rx_byte;
  logic rx_k;
  logic rx_valid;
  logic [7:0] line_tx_byte;
  logic line_tx_k;
  logic line_tx_idle;
  logic line_tx_neg_disp;
  logic [7:0] line_rx_byte = 8'h0;
  logic line_rx_k = 1'b0;
  logic line_rx_present = 1'b0;
  logic line_rx_lock = 1'b0;
  logic line_far_receiver = 1'b0;
  logic phy_in_reset;
  logic [1:0] phy_power_state;
  logic detect_found;
  logic loopback_active;
  logic tx_take;
  logic rx_strobe;
  logic line_tx_strobe;
  logic [31:0] rd;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  ppmp_if lnk ();
  ppmp_mac ppmp_mac_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_byte(tx_byte),
    .tx_k(tx_k), .tx_take(tx_take), .rx_byte(rx_byte), .rx_k(rx_k), .rx_valid(rx_valid),
    .rx_strobe(rx_strobe), .lnk(lnk));
  ppmp_phy ppmp_phy_inst (.clk(clk), .rst(rst), .lnk(lnk), .line_tx_byte(line_tx_byte),
    .line_tx_k(line_tx_k), .line_tx_idle(line_tx_idle), .line_tx_neg_disp(line_tx_neg_disp),
    .line_tx_strobe(line_tx_strobe), .line_rx_byte(line_rx_byte), .line_rx_k(line_rx_k),
    .line_rx_present(line_rx_present), .line_rx_lock(line_rx_lock),
    .line_far_receiver(line_far_receiver), .phy_in_reset(phy_in_reset),
    .phy_power_state(phy_power_state), .detect_found(detect_found),
    .loopback_active(loopback_active));
  ppmp_checker ppmp_checker_inst (.clk(clk), .rst(rst), .tx_byte_in(lnk.tx_byte_in),
    .detect_or_loopback_req(lnk.detect_or_loopback_req),
    .tx_electrical_idle_force(lnk.tx_electrical_idle_force), .phy_reset_n(lnk.phy_reset_n),
    .power_state_code_bit0(lnk.power_state_code_bit0),
    .power_state_code_bit1(lnk.power_state_code_bit1),
    .mac_source_clock(lnk.mac_source_clock), .phy_source_clock(lnk.phy_source_clock),
    .rx_lock_valid(lnk.rx_lock_valid), .phy_done_strobe(lnk.phy_done_strobe));
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // About six and a half times the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 15000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // Receive byte as the MAC should see it after optional inversion
  function automatic logic [7:0] exp_rx(input logic [7:0] b, input logic p);
    return p ? ~b : b;
  endfunction
  // Request stands until waitrequest is sampled low at a rising edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (SETTLE) @(posedge clk);
  endtask
  initial begin
    int c;
    int nt;
    int nr;
    int nl;
    logic [7:0] b;
    logic k;
    logic p;
    void'($urandom(21733));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(1'b1, phy_in_reset, "phy_in_reset")
    `CHK(PWR_RESET, phy_power_state, "power_state")
    `CHK(1'b1, line_tx_idle, "tx_idle")
    av(1'b0, OFS_CTRL, 32'h0);
    `CHK(32'h40, rd, "ctrl")
    av(1'b0, 4'hc, 32'h0);
    `CHK(32'h0, rd, "unmapped")
    av(1'b1, OFS_CTRL, 32'h10);
    settle();
    `CHK(1'b0, phy_in_reset, "phy_in_reset")
    av(1'b0, OFS_STATUS, 32'h0);
    `CHK(2'h3, {rd[3], rd[0]}, "status")
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'hbc : 8'($urandom);
      k = (i == 0) ? 1'b1 : 1'($urandom);
      tx_byte <= b;
      tx_k <= k;
      settle();
      `CHK(b, line_tx_byte, "line_tx_byte")
      `CHK(k, line_tx_k, "line_tx_k")
      `CHK(1'b0, line_tx_idle, "tx_idle")
    end
    // One take, one receive sample and one line symbol per link period
    nt = 0;
    nr = 0;
    nl = 0;
    repeat (SETTLE) begin
      @(posedge clk);
      nt += int'(tx_take === 1'b1);
      nr += int'(rx_strobe === 1'b1);
      nl += int'(line_tx_strobe === 1'b1);
    end
    `CHK(SETTLE / (2 * LINK_HALF_CYC), nt, "tx_take count")
    `CHK(SETTLE / (2 * LINK_HALF_CYC), nr, "rx_strobe count")
    `CHK(SETTLE / (2 * LINK_HALF_CYC), nl, "line_tx_strobe count")
    for (int i = 0; i < 2; i++) begin
      av(1'b1, OFS_CTRL, 32'h10 | (32'h2 << i));
      settle();
      `CHK(i == 0, line_tx_idle, "tx_idle")
      `CHK(i == 1, line_tx_neg_disp, "neg_disp")
    end
    line_rx_present <= 1'b1;
    line_rx_lock <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      k = 1'($urandom);
      p = i[0];
      line_rx_byte <= b;
      line_rx_k <= k;
      av(1'b1, OFS_CTRL, {28'h1, p, 3'h0});
      settle();
      `CHK(exp_rx(b, p), rx_byte, "rx_byte")
      `CHK(k, rx_k, "rx_k")
      `CHK(1'b1, rx_valid, "rx_valid")
      av(1'b0, OFS_RX_LAST, 32'h0);
      `CHK({1'b1, k, exp_rx(b, p)}, rd[9:0], "rx_last")
    end
    b = 8'($urandom);
    tx_byte <= b;
    tx_k <= 1'b1;
    av(1'b1, OFS_CTRL, 32'h11);
    settle();
    `CHK(1'b1, loopback_active, "loopback")
    `CHK({1'b1, b}, {rx_k, rx_byte}, "loopback_rx")
    line_rx_lock <= 1'b0;
    av(1'b1, OFS_CTRL, 32'h10);
    settle();
    `CHK(1'b0, rx_valid, "rx_valid")
    line_rx_lock <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      c = (i + 1) % 4;
      av(1'b1, OFS_STATUS, 32'h1);
      av(1'b1, OFS_CTRL, 32'h10 | (32'(c) << CTL_PWR));
      settle();
      `CHK(2'(c), phy_power_state, "power_state")
      `CHK(c < 2, rx_valid, "rx_valid")
      av(1'b0, OFS_STATUS, 32'h0);
      `CHK(1'b1, rd[0], "done")
      if (c == 1 || c == 2) begin
        `CHK(1'b1, line_tx_idle, "tx_idle")
      end
    end
    for (int i = 0; i < 2; i++) begin
      line_far_receiver <= i[0];
      av(1'b1, OFS_CTRL, 32'h50);
      settle();
      av(1'b1, OFS_STATUS, 32'h1);
      av(1'b1, OFS_CTRL, 32'h51);
      repeat (3) settle();
      `CHK(i[0], detect_found, "detect_found")
      av(1'b0, OFS_STATUS, 32'h0);
      `CHK(1'b1, rd[0], "done")
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
